// File: ccc_top.sv
// ccc_top: chain communication control with its Wishbone register file.
// assumes a classic Wishbone master on clk and frame, power and fault
// status from logic on the same clock.
// What this block does
// - chain port tx/rx enables follow direction select and stack-end setting
// - base device in reverse direction disables upper port, enables lower
// - stack-end device in reverse direction turns off its lower transmitter
// - broken cable: each side reached by its own direction setting
// - two timeout counters watch for missing valid frames
// - counters run in ACTIVE, clear in SHUTDOWN, freeze in SLEEP
// - short timeout restarts on valid frame, expiry sets short flag
// - long timeout expiry sets flag and sleeps, or shuts down
// - writing 0xA5 to unlock enters debug mode, debug controls apply
// - any other unlock value leaves debug, ports and UART normal
// - user chain control in debug makes ports follow second debug reg
// - user UART control lets chain traffic mirror onto UART
// - without user UART control UART debug functions are off
// - user UART control with baud bit gives 250 kbps, else 1 Mbps
// - debug status shows control owner and port states, always readable
// - multidrop disables both chain ports unless user chain control in debug, UART commands still work
// - multidrop broadcast read: stack end answers first, lower ones follow
// - lower-level fault status readable without debug unlock
// - written direction address takes effect at once as device address
`timescale 1ns/1ps
module ccc_top
	import ccc_pkg::*;
#(
	parameter int unsigned UNIT_CYC = TO_UNIT_CYC
)(
	input  wire logic              clk,
	input  wire logic              reset_n,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// frame and power context
	input  wire logic              valid_frame,
	input  wire logic [1:0]        power_mode,
	input  wire logic              bcast_read_req,
	input  wire logic              peer_resp_done,
	input  wire logic [DEV_AW-1:0] peer_resp_addr,
	input  wire logic [7:0]        uart_fault,
	input  wire logic [7:0]        upper_fault,
	input  wire logic [7:0]        lower_fault,
	// port and mode control
	output logic                   upper_tx_en,
	output logic                   upper_rx_en,
	output logic                   lower_tx_en,
	output logic                   lower_rx_en,
	output logic                   uart_tx_en,
	output logic                   uart_mirror_en,
	output logic                   uart_baud_slow,
	output logic [DEV_AW-1:0]      comm_address,
	output logic                   debug_mode,
	output logic                   sleep_req,
	output logic                   shutdown_req,
	output logic                   resp_start
);

	logic              dir_sel;
	logic              stack_member_flag;
	logic              stack_end_device;
	logic              multidrop;
	logic [DEV_AW-1:0] forward_address;
	logic [DEV_AW-1:0] reverse_address;
	logic [8:0]        timeout_config;
	logic              short_timeout_flag;
	logic              long_timeout_flag;
	logic [7:0]        unlock_value;
	logic [4:0]        debug_link_ctrl_a;
	logic [3:0]        debug_link_ctrl_b;
	logic              wr;
	logic              rd_strobe;
	logic [31:0]       next_rdata;
	logic              short_expire;
	logic              long_expire;
	logic              short_restart;
	logic              long_restart;
	logic              is_active;
	logic              is_shutdown;
	logic              daisy_user;
	logic              uart_user;
	logic              next_up_tx;
	logic              next_up_rx;
	logic              next_lo_tx;
	logic              next_lo_rx;
	logic [TO_CNT_W-1:0] short_count;
	logic [TO_CNT_W-1:0] long_count;
	ccc_resp_e         resp_state;

	// a write lands on the edge where ack rises
	assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_strobe = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= rd_strobe;
	end

	// direction and stack configuration
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dir_sel           <= 1'b0;
			stack_member_flag <= 1'b0;
			stack_end_device  <= 1'b0;
			multidrop         <= 1'b0;
		end
		else if (wr && wb_sel_i[0])
		begin
			if (wb_adr_i == ADR_PRIMARY)
				dir_sel <= wb_dat_i[PC_DIR_SEL];
			if (wb_adr_i == ADR_LINK)
			begin
				stack_member_flag <= wb_dat_i[LC_STACK_MEMBER];
				stack_end_device  <= wb_dat_i[LC_STACK_END];
				multidrop         <= wb_dat_i[LC_MULTIDROP];
			end
		end
	end

	// one address per direction; the selected one is live at once
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			forward_address <= RST_DEV_ADDR;
			reverse_address <= RST_DEV_ADDR;
		end
		else if (wr && wb_sel_i[0])
		begin
			if (wb_adr_i == ADR_FWD_ADDR)
				forward_address <= wb_dat_i[DEV_AW-1:0];
			if (wb_adr_i == ADR_REV_ADDR)
				reverse_address <= wb_dat_i[DEV_AW-1:0];
		end
	end

	assign comm_address = dir_sel ? reverse_address : forward_address;

	// timeout configuration, byte lanes honoured
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			timeout_config <= RST_TIMEOUT;
		else if (wr && wb_adr_i == ADR_TIMEOUT)
		begin
			if (wb_sel_i[0])
				timeout_config[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				timeout_config[8] <= wb_dat_i[8];
		end
	end

	// period change restarts the counter so the new period applies at once
	assign short_restart = valid_frame || (wr && wb_sel_i[0] && wb_adr_i == ADR_TIMEOUT
		&& wb_dat_i[2:0] != timeout_config[2:0]);
	assign long_restart  = valid_frame || (wr && wb_sel_i[0] && wb_adr_i == ADR_TIMEOUT
		&& wb_dat_i[6:4] != timeout_config[6:4]);
	assign is_active     = (power_mode == PM_ACTIVE);
	assign is_shutdown   = (power_mode == PM_SHUTDOWN);

	// two independent counters gated by their own enables
	ccc_timer #(
		.UNIT_CYC (UNIT_CYC),
		.CNT_W    (TO_CNT_W)
	) u_short_timer (
		.clk      (clk),
		.reset_n  (reset_n),
		.enable   (timeout_config[TO_SHORT_EN]),
		.active   (is_active),
		.shutdown (is_shutdown),
		.restart  (short_restart),
		.period   (timeout_config[TO_SHORT_LSB +: PERIOD_W]),
		.count    (short_count),
		.expire   (short_expire)
	);

	ccc_timer #(
		.UNIT_CYC (UNIT_CYC),
		.CNT_W    (TO_CNT_W)
	) u_long_timer (
		.clk      (clk),
		.reset_n  (reset_n),
		.enable   (timeout_config[TO_LONG_EN]),
		.active   (is_active),
		.shutdown (is_shutdown),
		.restart  (long_restart),
		.period   (timeout_config[TO_LONG_LSB +: PERIOD_W]),
		.count    (long_count),
		.expire   (long_expire)
	);

	// sticky fault flags, write one to clear; a same-cycle expiry wins
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			short_timeout_flag <= 1'b0;
			long_timeout_flag  <= 1'b0;
		end
		else
		begin
			if (short_expire)
				short_timeout_flag <= 1'b1;
			else if (wr && wb_sel_i[0] && wb_adr_i == ADR_FAULT && wb_dat_i[FS_SHORT])
				short_timeout_flag <= 1'b0;
			if (long_expire && !timeout_config[TO_LONG_ACT])
				long_timeout_flag <= 1'b1;
			else if (wr && wb_sel_i[0] && wb_adr_i == ADR_FAULT && wb_dat_i[FS_LONG])
				long_timeout_flag <= 1'b0;
		end
	end

	// mode requests to the power controller, one-cycle pulses
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sleep_req    <= 1'b0;
			shutdown_req <= 1'b0;
		end
		else
		begin
			sleep_req    <= long_expire && !timeout_config[TO_LONG_ACT];
			shutdown_req <= long_expire && timeout_config[TO_LONG_ACT];
		end
	end

	// debug unlock and debug control registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			unlock_value      <= RST_UNLOCK;
			debug_link_ctrl_a <= RST_DBG_A;
			debug_link_ctrl_b <= RST_DBG_B;
		end
		else if (wr && wb_sel_i[0])
		begin
			if (wb_adr_i == ADR_UNLOCK)
				unlock_value <= wb_dat_i[7:0];
			if (wb_adr_i == ADR_DBG_A)
				debug_link_ctrl_a <= wb_dat_i[4:0];
			if (wb_adr_i == ADR_DBG_B)
				debug_link_ctrl_b <= wb_dat_i[3:0];
		end
	end

	// debug settings only bite while unlocked; the stored bits are kept
	assign debug_mode = (unlock_value == UNLOCK_CODE);
	assign daisy_user = debug_mode && debug_link_ctrl_a[DA_USER_DAISY];
	assign uart_user  = debug_mode && debug_link_ctrl_a[DA_USER_UART];

	// chain port enables: the upstream port faces away from the host
	always_comb
	begin
		next_up_tx = 1'b0;
		next_up_rx = 1'b0;
		next_lo_tx = 1'b0;
		next_lo_rx = 1'b0;
		if (daisy_user)
		begin
			next_up_tx = debug_link_ctrl_b[DB_UP_TX];
			next_up_rx = debug_link_ctrl_b[DB_UP_RX];
			next_lo_tx = debug_link_ctrl_b[DB_LO_TX];
			next_lo_rx = debug_link_ctrl_b[DB_LO_RX];
		end
		else if (multidrop)
		begin
			next_up_tx = 1'b0;
		end
		else if (!dir_sel)
		begin
			next_up_tx = !stack_end_device || !stack_member_flag;
			next_up_rx = 1'b1;
			next_lo_tx = stack_member_flag;
			next_lo_rx = stack_member_flag;
		end
		else
		begin
			next_lo_tx = !stack_end_device || !stack_member_flag;
			next_lo_rx = 1'b1;
			next_up_tx = stack_member_flag;
			next_up_rx = stack_member_flag;
		end
	end

	// registered so the port drivers never see a glitch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			upper_tx_en <= 1'b0;
			upper_rx_en <= 1'b0;
			lower_tx_en <= 1'b0;
			lower_rx_en <= 1'b0;
		end
		else
		begin
			upper_tx_en <= next_up_tx;
			upper_rx_en <= next_up_rx;
			lower_tx_en <= next_lo_tx;
			lower_rx_en <= next_lo_rx;
		end
	end

	// uart: stack devices keep tx off unless the user turns it on
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			uart_tx_en     <= 1'b0;
			uart_mirror_en <= 1'b0;
			uart_baud_slow <= 1'b0;
		end
		else
		begin
			uart_tx_en     <= !stack_member_flag
				|| (uart_user && debug_link_ctrl_a[DA_UART_TX]);
			uart_mirror_en <= uart_user && debug_link_ctrl_a[DA_MIRROR];
			uart_baud_slow <= uart_user && debug_link_ctrl_a[DA_BAUD];
		end
	end

	// multidrop broadcast read: answer after the next-higher address has
	// answered; a lost peer answer leaves this device waiting until reconfigured
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			resp_state <= RESP_IDLE;
			resp_start <= 1'b0;
		end
		else
		begin
			resp_start <= 1'b0;
			case (resp_state)
				RESP_IDLE:
				begin
					if (multidrop && bcast_read_req)
					begin
						if (stack_end_device)
							resp_start <= 1'b1;
						else
							resp_state <= RESP_WAIT;
					end
				end
				RESP_WAIT:
				begin
					if (!multidrop)
						resp_state <= RESP_IDLE;
					else if (peer_resp_done
						&& peer_resp_addr == DEV_AW'(comm_address + DEV_AW'(1)))
					begin
						resp_start <= 1'b1;
						resp_state <= RESP_IDLE;
					end
				end
				default:
					resp_state <= RESP_IDLE;
			endcase
		end
	end

	// read mux; status and fault views need no unlock
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			ADR_PRIMARY:  next_rdata[PC_DIR_SEL] = dir_sel;
			ADR_LINK:     next_rdata[2:0] = {multidrop, stack_end_device, stack_member_flag};
			ADR_FWD_ADDR: next_rdata[DEV_AW-1:0] = forward_address;
			ADR_REV_ADDR: next_rdata[DEV_AW-1:0] = reverse_address;
			ADR_TIMEOUT:  next_rdata[8:0] = timeout_config;
			ADR_FAULT:    next_rdata[1:0] = {long_timeout_flag, short_timeout_flag};
			ADR_UNLOCK:   next_rdata[7:0] = unlock_value;
			ADR_DBG_A:    next_rdata[4:0] = debug_link_ctrl_a;
			ADR_DBG_B:    next_rdata[3:0] = debug_link_ctrl_b;
			ADR_DBG_STAT: next_rdata[6:0] = {debug_mode, lower_rx_en, lower_tx_en,
				upper_rx_en, upper_tx_en, daisy_user, uart_user};
			ADR_DBG_FLT:  next_rdata[23:0] = {lower_fault, upper_fault, uart_fault};
			default:      next_rdata = 32'h0000_0000;
		endcase
	end

	// read data held from the ack cycle until the next read
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wb_dat_o <= 32'h0000_0000;
		else if (rd_strobe && !wb_we_i)
			wb_dat_o <= next_rdata;
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence unlock_write_s;
		wr && wb_sel_i[0] && wb_adr_i == ADR_UNLOCK;
	endsequence

	sequence stack_end_bcast_s;
		resp_state == RESP_IDLE && multidrop && stack_end_device && bcast_read_req;
	endsequence

	chk_multidrop_ports_off: assert property (
		multidrop && !daisy_user |=> !upper_tx_en && !upper_rx_en && !lower_tx_en && !lower_rx_en)
		else $error("chain port enabled in multidrop");

	chk_base_reverse_ports: assert property (
		!daisy_user && !multidrop && !stack_member_flag && dir_sel
		|=> !upper_tx_en && !upper_rx_en && lower_tx_en && lower_rx_en)
		else $error("base device ports wrong in reverse direction");

	chk_end_lower_tx: assert property (
		!daisy_user && !multidrop && stack_member_flag && stack_end_device && dir_sel
		|=> !lower_tx_en && upper_tx_en)
		else $error("stack end lower transmitter not off");

	chk_unlock_enter: assert property (
		unlock_write_s ##0 wb_dat_i[7:0] == UNLOCK_CODE |=> debug_mode [*1] ##1 debug_mode)
		else $error("unlock code did not enter debug mode");

	chk_unlock_leave: assert property (
		unlock_write_s ##0 wb_dat_i[7:0] != UNLOCK_CODE |=> !debug_mode ##1 !uart_baud_slow)
		else $error("debug mode kept after other unlock value");

	chk_uart_normal_rate: assert property (
		!uart_user |=> !uart_baud_slow && !uart_mirror_en)
		else $error("uart debug function active without user control");

	chk_short_flag_set: assert property (
		short_expire |=> short_timeout_flag)
		else $error("short timeout flag not set on expiry");

	chk_long_action: assert property (
		long_expire |=> (sleep_req == !$past(timeout_config[TO_LONG_ACT]))
			&& (shutdown_req == $past(timeout_config[TO_LONG_ACT])))
		else $error("long timeout action wrong");

	chk_sleep_freeze: assert property (
		power_mode == PM_SLEEP && $past(power_mode) == PM_SLEEP |-> $stable(short_count)
			|| !timeout_config[TO_SHORT_EN])
		else $error("short counter moved in sleep");

	chk_shutdown_clear: assert property (
		is_shutdown |=> short_count == '0 && long_count == '0)
		else $error("counters not cleared in shutdown");

	chk_disabled_silent: assert property (
		!timeout_config[TO_SHORT_EN] && !$past(timeout_config[TO_SHORT_EN])
		|-> !short_expire ##1 short_count == '0)
		else $error("disabled short timeout still active");

	chk_end_answers_first: assert property (
		stack_end_bcast_s |=> resp_start)
		else $error("stack end did not answer broadcast read");

	chk_address_live: assert property (
		wr && wb_sel_i[0] && wb_adr_i == ADR_REV_ADDR && dir_sel
		|=> comm_address == $past(wb_dat_i[DEV_AW-1:0]))
		else $error("reverse address not live at once");

endmodule // ccc_top

// File: ccc_pkg.sv
// ccc_pkg: register map, field positions, reset values, modes and timing
// counts shared by the chain communication control block and its timer.
// assumes a single 50 MHz system clock.
package ccc_pkg;

	// clock and timeout step
	localparam int unsigned CLK_FREQ_HZ = 50_000_000;
	localparam int unsigned TO_UNIT_US  = 1000;       // one period step, in microseconds
	localparam int unsigned TO_UNIT_CYC = TO_UNIT_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned TO_CNT_W    = 32;

	// widths
	localparam int unsigned ADR_W    = 8;
	localparam int unsigned DEV_AW   = 6;
	localparam int unsigned PERIOD_W = 3;

	// register byte offsets
	localparam logic [7:0] ADR_PRIMARY  = 8'h00;
	localparam logic [7:0] ADR_LINK     = 8'h04;
	localparam logic [7:0] ADR_FWD_ADDR = 8'h08;
	localparam logic [7:0] ADR_REV_ADDR = 8'h0C;
	localparam logic [7:0] ADR_TIMEOUT  = 8'h10;
	localparam logic [7:0] ADR_FAULT    = 8'h14;
	localparam logic [7:0] ADR_UNLOCK   = 8'h18;
	localparam logic [7:0] ADR_DBG_A    = 8'h1C;
	localparam logic [7:0] ADR_DBG_B    = 8'h20;
	localparam logic [7:0] ADR_DBG_STAT = 8'h24;
	localparam logic [7:0] ADR_DBG_FLT  = 8'h28;

	// field positions
	localparam int unsigned PC_DIR_SEL      = 0;
	localparam int unsigned LC_STACK_MEMBER = 0;
	localparam int unsigned LC_STACK_END    = 1;
	localparam int unsigned LC_MULTIDROP    = 2;
	localparam int unsigned TO_SHORT_LSB    = 0;
	localparam int unsigned TO_SHORT_EN     = 3;
	localparam int unsigned TO_LONG_LSB     = 4;
	localparam int unsigned TO_LONG_EN      = 7;
	localparam int unsigned TO_LONG_ACT     = 8;
	localparam int unsigned FS_SHORT        = 0;
	localparam int unsigned FS_LONG         = 1;
	localparam int unsigned DA_USER_DAISY   = 0;
	localparam int unsigned DA_USER_UART    = 1;
	localparam int unsigned DA_MIRROR       = 2;
	localparam int unsigned DA_UART_TX      = 3;
	localparam int unsigned DA_BAUD         = 4;
	localparam int unsigned DB_UP_TX        = 0;
	localparam int unsigned DB_UP_RX        = 1;
	localparam int unsigned DB_LO_TX        = 2;
	localparam int unsigned DB_LO_RX        = 3;

	// codes and reset values
	localparam logic [7:0] UNLOCK_CODE  = 8'hA5;
	localparam logic [7:0] RST_UNLOCK   = 8'h00;
	localparam logic [8:0] RST_TIMEOUT  = 9'h000;
	localparam logic [5:0] RST_DEV_ADDR = 6'h00;
	localparam logic [4:0] RST_DBG_A    = 5'h00;
	localparam logic [3:0] RST_DBG_B    = 4'h0;

	typedef enum logic [1:0] {
		PM_ACTIVE   = 2'b00,
		PM_SLEEP    = 2'b01,
		PM_SHUTDOWN = 2'b10
	} ccc_pmode_e;

	typedef enum logic {
		RESP_IDLE = 1'b0,
		RESP_WAIT = 1'b1
	} ccc_resp_e;

endpackage

// File: ccc_timer.sv
// ccc_timer: one programmable communication-loss timeout counter.
// assumes restart and mode inputs come from logic on the same clock.
`timescale 1ns/1ps
module ccc_timer
	import ccc_pkg::*;
#(
	parameter int unsigned UNIT_CYC = TO_UNIT_CYC,
	parameter int unsigned CNT_W    = TO_CNT_W
)(
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                enable,
	input  wire logic                active,
	input  wire logic                shutdown,
	input  wire logic                restart,
	input  wire logic [PERIOD_W-1:0] period,
	output logic      [CNT_W-1:0]    count,
	output logic                     expire
);

	logic [CNT_W-1:0] limit;
	logic             at_end;

	// period step count; field 0 still gives one full step
	assign limit  = CNT_W'((32'(period) + 32'h1) * 32'(UNIT_CYC));
	assign at_end = (count == limit - CNT_W'(1));

	// counts only while active; sleep freezes, shutdown or disable clears
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			count <= '0;
		else if (shutdown || !enable)
			count <= '0;
		else if (active)
		begin
			if (restart || at_end)
				count <= '0;
			else
				count <= count + CNT_W'(1);
		end
	end

	// one-cycle expiry pulse, then the counter re-arms
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			expire <= 1'b0;
		else
			expire <= active && enable && !shutdown && !restart && at_end;
	end

endmodule // ccc_timer

// File: ccc_host_model.sv
// ccc_host_model: far-side host that keeps the link busy with good frames.
// assumes the bench clock and reset; a frame shows as a one-cycle pulse.
`timescale 1ns/1ps
module ccc_host_model
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic frames_on,
	output logic      valid_frame
);
	logic phase;

	// a frame every second cycle, shorter than the shortest timeout
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase       <= 1'b0;
			valid_frame <= 1'b0;
		end
		else
		begin
			phase       <= ~phase;
			valid_frame <= frames_on & phase;
		end
	end
endmodule // ccc_host_model

// File: chain_comm_control_tb.sv
// chain_comm_control_tb: self-checking bench for ccc_top.
// assumes ccc_pkg and ccc_host_model; timeout step shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module chain_comm_control_tb
	import ccc_pkg::*;
;
	logic        clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        frames_on = 1'b0, breq = 1'b0, vf, ack;
	logic        up_tx, up_rx, lo_tx, lo_rx, dbg, slp, shd, rsp, baud;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [23:0] flt = 24'h3CC35A;
	logic [1:0]  pmode = PM_ACTIVE;
	logic [5:0]  caddr;
	logic        pdone = 1'b0, utx, umir;
	logic [5:0]  paddr = 6'h00;
	int          mismatches = 0, samples_checked = 0;

	// 50 MHz
	always #10 clk = ~clk;

	ccc_top #(.UNIT_CYC(4)) ccc_top_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .valid_frame(vf), .power_mode(pmode),
		.bcast_read_req(breq), .peer_resp_done(pdone), .peer_resp_addr(paddr),
		.uart_fault(flt[7:0]), .upper_fault(flt[15:8]), .lower_fault(flt[23:16]),
		.upper_tx_en(up_tx), .upper_rx_en(up_rx), .lower_tx_en(lo_tx),
		.lower_rx_en(lo_rx), .uart_tx_en(utx), .uart_mirror_en(umir), .uart_baud_slow(baud),
		.comm_address(caddr), .debug_mode(dbg), .sleep_req(slp), .shutdown_req(shd),
		.resp_start(rsp));

	ccc_host_model ccc_host_model_i (.clk(clk), .reset_n(reset_n),
		.frames_on(frames_on), .valid_frame(vf));

	task automatic wrap_up;
		$display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// classic cycle: hold the request until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
		begin
			mismatches++;
			wrap_up();
		end
	endtask

	// request pulses are one cycle, so poll at every edge
	task automatic wait_req(input logic sh);
		int n;
		n = 0;
		while ((sh ? shd : slp) !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		`CHK((n < 40), 1'b1)
		if (n >= 40)
			wrap_up();
	endtask

	task automatic t_dir;
		`CHK(({up_tx, up_rx, lo_tx, lo_rx}), 4'b1100)
		wb(1'b1, ADR_PRIMARY, 32'h1);
		wb(1'b1, ADR_REV_ADDR, 32'h2A);
		repeat (3) @(posedge clk);
		`CHK(({up_tx, up_rx, lo_tx, lo_rx}), 4'b0011)
		`CHK(caddr, 6'h2A)
		wb(1'b1, ADR_LINK, 32'h3);
		repeat (3) @(posedge clk);
		`CHK(({up_tx, up_rx, lo_tx, lo_rx}), 4'b1101)
		`CHK(utx, 1'b0)
		wb(1'b1, ADR_LINK, 32'h0);
		wb(1'b1, ADR_PRIMARY, 32'h0);
	endtask

	task automatic t_timer;
		frames_on <= 1'b1;
		wb(1'b1, ADR_TIMEOUT, 32'h008);
		wb(1'b1, ADR_FAULT, 32'h3);
		repeat (20) @(posedge clk);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK(q[1:0], 2'b00)
		frames_on <= 1'b0;
		repeat (20) @(posedge clk);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK(q[1:0], 2'b01)
		pmode <= PM_SLEEP;
		wb(1'b1, ADR_FAULT, 32'h3);
		repeat (20) @(posedge clk);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK(q[1:0], 2'b00)
		pmode <= PM_SHUTDOWN;
		wb(1'b1, ADR_FAULT, 32'h3);
		repeat (20) @(posedge clk);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK(q[1:0], 2'b00)
		pmode <= PM_ACTIVE;
		wb(1'b1, ADR_TIMEOUT, 32'h080);
		wait_req(1'b0);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK(q[1], 1'b1)
		wb(1'b1, ADR_TIMEOUT, 32'h180);
		wait_req(1'b1);
		wb(1'b1, ADR_TIMEOUT, 32'h000);
		wb(1'b1, ADR_FAULT, 32'h3);
		repeat (20) @(posedge clk);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK(q[1:0], 2'b00)
	endtask

	task automatic t_debug;
		wb(1'b1, ADR_UNLOCK, 32'hA5);
		wb(1'b1, ADR_DBG_A, 32'h16);
		repeat (3) @(posedge clk);
		`CHK(dbg, 1'b1)
		`CHK(baud, 1'b1)
		`CHK(umir, 1'b1)
		wb(1'b1, ADR_DBG_A, 32'h10);
		repeat (3) @(posedge clk);
		`CHK(baud, 1'b0)
		`CHK(umir, 1'b0)
		wb(1'b1, ADR_DBG_A, 32'h01);
		repeat (3) @(posedge clk);
		`CHK(({up_tx, up_rx}), 2'b00)
		wb(1'b0, ADR_DBG_STAT, 32'h0);
		`CHK(q[6:0], 7'h42)
		wb(1'b1, ADR_UNLOCK, 32'h00);
		repeat (3) @(posedge clk);
		`CHK(dbg, 1'b0)
		`CHK(({up_tx, up_rx}), 2'b11)
		wb(1'b0, ADR_DBG_STAT, 32'h0);
		`CHK(q[6:0], 7'h0C)
		wb(1'b0, ADR_DBG_FLT, 32'h0);
		`CHK(q, ({8'h00, flt}))
		wb(1'b0, 8'h30, 32'h0);
		`CHK(q, 32'h0)
	endtask

	task automatic t_mdrop;
		wb(1'b1, ADR_LINK, 32'h7);
		repeat (3) @(posedge clk);
		`CHK(({up_tx, up_rx, lo_tx, lo_rx}), 4'b0000)
		@(posedge clk);
		breq <= 1'b1;
		@(posedge clk);
		breq <= 1'b0;
		@(posedge clk);
		`CHK(rsp, 1'b1)
		// a lower member waits for the answer of the next-higher address
		wb(1'b1, ADR_LINK, 32'h5);
		@(posedge clk);
		breq <= 1'b1;
		@(posedge clk);
		breq <= 1'b0;
		pdone <= 1'b1;
		paddr <= 6'h01;
		@(posedge clk);
		pdone <= 1'b0;
		`CHK(rsp, 1'b0)
		@(posedge clk);
		`CHK(rsp, 1'b1)
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_dir();
		t_timer();
		t_debug();
		t_mdrop();
		wrap_up();
	end
endmodule // chain_comm_control_tb
